//--- hw/instr_subset_pkg.sv
// Constants, opcodes, state carrier and register map of the instruction subset unit.
// Assumes a single 100 MHz core clock and an APB master for the status window.
package instr_subset_pkg;
   localparam int INSTR_W = 12;
   localparam int PC_W = 9;
   localparam logic [11:0] OP_FILE_OP_MASK = 12'hfc0;
   localparam logic [11:0] OP_ROTATE = 12'h300;
   localparam logic [11:0] OP_SUBTRACT = 12'h080;
   localparam logic [11:0] OP_RETURN_MASK = 12'hf00;
   localparam logic [11:0] OP_RETURN_LIT = 12'h800;
   localparam logic [11:0] OP_SLEEP = 12'h003;
   localparam int FADDR_MSB = 4;
   localparam int DEST_BIT = 5;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic EXPIRY_RESET = 1'b1;
   localparam logic SLEPT_RESET = 1'b1;
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_CONTROL = 12'h004;
   localparam int CTRL_WAKE_BIT = 0;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_REFETCH = 2'b01,
      ST_ASLEEP = 2'b10
   } exec_state_t;

   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic dc;
      logic zero;
   } alu_out_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic we;
   } file_wr_t;

   typedef struct packed {
      exec_state_t st;
      logic [7:0] acc;
      logic carry;
      logic dc;
      logic zero;
      logic expiry;
      logic slept;
      logic pin_wake;
      file_wr_t fw;
      logic pc_load;
      logic [PC_W-1:0] pc_val;
      logic pop;
      logic watchdog_clr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } core_state_t;
endpackage

//--- hw/subset_alu.sv
// Combinational rotate and subtract datapath with flag generation.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/1ps
module subset_alu (
   input wire logic [7:0] file_val_i,
   input wire logic [7:0] acc_i,
   input wire logic carry_i,
   input wire logic sub_i,
   output instr_subset_pkg::alu_out_t out_o
);
   import instr_subset_pkg::*;
   logic [8:0] diff;
   logic [4:0] low_diff;

   // Two's complement: f + ~w + 1, carry out is the inverted borrow
   assign diff = {1'b0, file_val_i} + {1'b0, ~acc_i} + 9'h001;
   assign low_diff = {1'b0, file_val_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

   always_comb begin
      if (sub_i) begin
         out_o.result = diff[7:0];
         out_o.carry = diff[8];
         out_o.dc = low_diff[4];
         out_o.zero = (diff[7:0] == 8'h00);
      end else begin
         out_o.result = {carry_i, file_val_i[7:1]};
         out_o.carry = file_val_i[0];
         out_o.dc = 1'b0;
         out_o.zero = 1'b0;
      end
   end
endmodule

//--- hw/instr_subset_core.sv
// Execute stage for literal return, rotate right, sleep and subtract.
// Assumes file_rdata_i already holds the register addressed by instr_i[4:0].
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module instr_subset_core (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic instr_valid_i,
   input wire logic [instr_subset_pkg::INSTR_W-1:0] instr_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic [instr_subset_pkg::PC_W-1:0] stack_top_i,
   input wire logic wake_i,
   input wire logic pin_change_wake_flag_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic busy_o,
   output logic sleeping_o,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic dc_o,
   output logic zero_o,
   output logic expiry_status_flag_o,
   output logic sleep_entered_flag_o,
   output logic pin_change_wake_flag_o,
   output logic [4:0] file_addr_o,
   output logic [7:0] file_wdata_o,
   output logic file_we_o,
   output logic pc_load_o,
   output logic [instr_subset_pkg::PC_W-1:0] pc_value_o,
   output logic stack_pop_o,
   output logic watchdog_clear_o,
   output logic watchdog_prescaler_clear_o
);
   import instr_subset_pkg::*;

   core_state_t state_reg;
   core_state_t state_next;
   alu_out_t alu;
   logic accept;
   logic is_rrf;
   logic is_sub;
   logic is_ret;
   logic is_sleep;
   logic dest_file;
   logic wake_req;
   logic apb_access;

   assign accept = instr_valid_i && (state_reg.st == ST_RUN);
   assign is_rrf = (instr_i & OP_FILE_OP_MASK) == OP_ROTATE;
   assign is_sub = (instr_i & OP_FILE_OP_MASK) == OP_SUBTRACT;
   assign is_ret = (instr_i & OP_RETURN_MASK) == OP_RETURN_LIT;
   assign is_sleep = instr_i == OP_SLEEP;
   assign dest_file = instr_i[DEST_BIT];
   assign apb_access = psel && penable && !state_reg.pready;
   assign wake_req = wake_i || (apb_access && pwrite && paddr == ADDR_CONTROL
                                && pwdata[CTRL_WAKE_BIT]);

   subset_alu u_alu (
      .file_val_i(file_rdata_i),
      .acc_i(state_reg.acc),
      .carry_i(state_reg.carry),
      .sub_i(is_sub),
      .out_o(alu)
   );

   always_comb begin
      state_next = state_reg;
      state_next.fw.we = 1'b0;
      state_next.pc_load = 1'b0;
      state_next.pop = 1'b0;
      state_next.watchdog_clr = 1'b0;
      state_next.pin_wake = pin_change_wake_flag_i;
      unique case (state_reg.st)
         ST_RUN: begin
            if (accept && is_ret) begin
               state_next.acc = instr_i[7:0];
               state_next.pc_load = 1'b1;
               state_next.pc_val = stack_top_i;
               state_next.pop = 1'b1;
               state_next.st = ST_REFETCH;
            end else if (accept && (is_rrf || is_sub)) begin
               state_next.carry = alu.carry;
               if (is_sub) begin
                  state_next.dc = alu.dc;
                  state_next.zero = alu.zero;
               end
               state_next.fw.addr = instr_i[FADDR_MSB:0];
               state_next.fw.wdata = alu.result;
               if (dest_file) begin
                  state_next.fw.we = 1'b1;
               end else begin
                  state_next.acc = alu.result;
               end
            end else if (accept && is_sleep) begin
               state_next.watchdog_clr = 1'b1;
               state_next.expiry = 1'b1;
               state_next.slept = 1'b0;
               state_next.st = ST_ASLEEP;
            end
         end
         ST_REFETCH: begin
            // Fetched word is stale after the jump, so this slot is dropped
            state_next.st = ST_RUN;
         end
         ST_ASLEEP: begin
            if (wake_req) begin
               state_next.st = ST_RUN;
            end
         end
         default: begin
            state_next.st = ST_RUN;
         end
      endcase
      // APB: one wait state so read data can come from a flop
      state_next.pready = apb_access;
      state_next.pslverr = 1'b0;
      if (apb_access) begin
         state_next.prdata = 32'h0000_0000;
         if (paddr == ADDR_STATUS) begin
            state_next.prdata = {16'h0000, state_reg.acc, 1'b0,
                                 state_reg.st == ST_ASLEEP, state_reg.pin_wake,
                                 state_reg.expiry, state_reg.slept,
                                 state_reg.zero, state_reg.dc, state_reg.carry};
            state_next.pslverr = pwrite;
         end else if (paddr != ADDR_CONTROL) begin
            state_next.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '{st: ST_RUN, acc: ACC_RESET, carry: 1'b0, dc: 1'b0, zero: 1'b0,
                        expiry: EXPIRY_RESET, slept: SLEPT_RESET, pin_wake: 1'b0,
                        fw: '0, pc_load: 1'b0, pc_val: '0, pop: 1'b0, watchdog_clr: 1'b0,
                        pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign prdata = state_reg.prdata;
   assign busy_o = state_reg.st == ST_REFETCH;
   assign sleeping_o = state_reg.st == ST_ASLEEP;
   assign acc_o = state_reg.acc;
   assign carry_o = state_reg.carry;
   assign dc_o = state_reg.dc;
   assign zero_o = state_reg.zero;
   assign expiry_status_flag_o = state_reg.expiry;
   assign sleep_entered_flag_o = state_reg.slept;
   assign pin_change_wake_flag_o = state_reg.pin_wake;
   assign file_addr_o = state_reg.fw.addr;
   assign file_wdata_o = state_reg.fw.wdata;
   assign file_we_o = state_reg.fw.we;
   assign pc_load_o = state_reg.pc_load;
   assign pc_value_o = state_reg.pc_val;
   assign stack_pop_o = state_reg.pop;
   // Counter and prescaler are cleared together by one strobe
   assign watchdog_clear_o = state_reg.watchdog_clr;
   assign watchdog_prescaler_clear_o = state_reg.watchdog_clr;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   logic [7:0] diff_chk;
   assign diff_chk = file_rdata_i - state_reg.acc;

   sequence ret_taken;
      accept && is_ret;
   endsequence
   sequence refetch_then_run;
      busy_o ##1 !busy_o;
   endsequence
   sequence sleep_taken;
      accept && is_sleep;
   endsequence

   AST_RET_LOADS: assert property (ret_taken |=> acc_o == $past(instr_i[7:0]) && pc_load_o
      && stack_pop_o && pc_value_o == $past(stack_top_i))
      else $error("literal return did not load acc and pc");
   AST_RET_TWO_CYCLES: assert property (ret_taken |=> refetch_then_run)
      else $error("literal return not two cycles");
   AST_RRF_CARRY: assert property (accept && is_rrf |=> carry_o == $past(file_rdata_i[0])
      && dc_o == $past(dc_o) && zero_o == $past(zero_o))
      else $error("rotate carry or other flags wrong");
   AST_RRF_TO_ACC: assert property (accept && is_rrf && !dest_file |=> !file_we_o
      && acc_o == {$past(carry_o), $past(file_rdata_i[7:1])})
      else $error("rotate to acc wrong");
   AST_RRF_TO_FILE: assert property (accept && is_rrf && dest_file |=> file_we_o
      && file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])} && acc_o == $past(acc_o))
      else $error("rotate to file wrong");
   AST_SLEEP_WDT: assert property (sleep_taken |=> watchdog_clear_o
      && watchdog_prescaler_clear_o ##1 !watchdog_clear_o)
      else $error("sleep did not clear watchdog once");
   AST_SLEEP_FLAGS: assert property (sleep_taken |=> expiry_status_flag_o && !sleep_entered_flag_o
      && pin_change_wake_flag_o == $past(pin_change_wake_flag_i))
      else $error("sleep status flags wrong");
   AST_SLEEP_HALT: assert property (sleep_taken ##1 !wake_req[*2] |=> sleeping_o && !file_we_o
      && !pc_load_o)
      else $error("core executed while asleep");
   AST_SUB_CARRY: assert property (accept && is_sub |=> carry_o == ($past(file_rdata_i) >= $past(acc_o))
      && zero_o == ($past(file_rdata_i) == $past(acc_o)))
      else $error("subtract carry or zero wrong");
   AST_SUB_DEST: assert property (accept && is_sub && dest_file |=> file_we_o
      && file_wdata_o == $past(diff_chk) && file_addr_o == $past(instr_i[4:0]))
      else $error("subtract to file wrong");
   AST_SUB_ACC: assert property (accept && is_sub && !dest_file |=> !file_we_o
      && acc_o == $past(diff_chk))
      else $error("subtract to acc wrong");

   sequence apb_waiting;
      psel && penable && !pready;
   endsequence
   sequence refetch_slot;
      busy_o;
   endsequence
   sequence asleep_no_wake;
      sleeping_o && !wake_req;
   endsequence
   sequence unknown_taken;
      accept && !(is_rrf || is_sub || is_ret || is_sleep);
   endsequence

   // Side effects that must not happen, plus digit carry, rotate file address, sleep entry and wake; a leaky strobe would
   // corrupt the file or the stack without touching acc
   AST_SUB_DC: assert property (accept && is_sub |=> dc_o
      == ($past(file_rdata_i[3:0]) >= $past(acc_o[3:0])))
      else $error("subtract digit carry wrong");
   AST_SUB_FILE_KEEPS_ACC: assert property (accept && is_sub && dest_file
      |=> acc_o == $past(acc_o))
      else $error("subtract to file changed acc");
   AST_RRF_FILE_ADDR: assert property (accept && is_rrf && dest_file
      |=> file_addr_o == $past(instr_i[4:0]))
      else $error("rotate file address wrong");
   AST_RET_KEEPS_FLAGS: assert property (ret_taken |=> carry_o == $past(carry_o)
      && dc_o == $past(dc_o) && zero_o == $past(zero_o))
      else $error("literal return changed flags");
   AST_PC_PULSE: assert property (pc_load_o |=> !pc_load_o)
      else $error("pc load longer than one cycle");
   AST_REFETCH_DROPS: assert property (refetch_slot |=> !file_we_o
      && !pc_load_o && !stack_pop_o && acc_o == $past(acc_o))
      else $error("refetch slot executed");
   AST_WDT_PULSE: assert property (watchdog_clear_o |=> !watchdog_clear_o)
      else $error("watchdog clear longer than one cycle");
   AST_SLEEP_KEEPS_ACC: assert property (sleep_taken |=> acc_o == $past(acc_o)
      && carry_o == $past(carry_o))
      else $error("sleep changed acc or carry");
   AST_SLEEP_ENTERS: assert property (sleep_taken |=> sleeping_o)
      else $error("sleep not entered");
   AST_ASLEEP_HOLDS: assert property (asleep_no_wake |=> sleeping_o
      && !file_we_o && !pc_load_o && acc_o == $past(acc_o))
      else $error("core left sleep without wake");
   AST_WAKE_LEAVES: assert property (sleeping_o && wake_req |=> !sleeping_o)
      else $error("wake did not end sleep");
   AST_UNKNOWN_IGNORED: assert property (unknown_taken |=> acc_o == $past(acc_o)
      && carry_o == $past(carry_o) && !file_we_o && !pc_load_o && !watchdog_clear_o)
      else $error("unknown opcode had an effect");

   // Status window is a side door for software; one wait state only
   AST_APB_ONE_WAIT: assert property (apb_waiting |=> pready)
      else $error("apb answer late");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("apb ready longer than one cycle");
   AST_APB_UNMAPPED: assert property (apb_access && paddr != ADDR_STATUS
      && paddr != ADDR_CONTROL |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped apb access not refused");
   AST_APB_STATUS_RO: assert property (apb_access && pwrite && paddr == ADDR_STATUS |=> pslverr)
      else $error("status write not refused");
endmodule

//--- tb/test_baseline_core_instr_subset.sv
// Self-checking bench for the rotate, subtract, literal return and sleep execute stage.
// Assumes instr_subset_core as the unit; the bench drives every port and models the flags.
`timescale 1ns/1ps
module test_baseline_core_instr_subset;
   import instr_subset_pkg::*;
   logic clk_i, reset_i, instr_valid_i, wake_i, pin_change_wake_flag_i;
   logic psel, penable, pwrite, pready, pslverr, busy_o, sleeping_o, er;
   logic [11:0] instr_i, paddr, k;
   logic [7:0] file_rdata_i, acc_o, file_wdata_o, acc_m;
   logic [PC_W-1:0] stack_top_i, pc_value_o;
   logic [31:0] pwdata, prdata, rd;
   logic carry_o, dc_o, zero_o, expiry_status_flag_o, sleep_entered_flag_o;
   logic pin_change_wake_flag_o, file_we_o, pc_load_o, stack_pop_o;
   logic watchdog_clear_o, watchdog_prescaler_clear_o, c_m, dc_m, z_m, ex_m, sl_m;
   logic [4:0] file_addr_o;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;

   instr_subset_core u_dut (
      .clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .file_rdata_i(file_rdata_i), .stack_top_i(stack_top_i), .wake_i(wake_i),
      .pin_change_wake_flag_i(pin_change_wake_flag_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .busy_o(busy_o), .sleeping_o(sleeping_o), .acc_o(acc_o),
      .carry_o(carry_o), .dc_o(dc_o), .zero_o(zero_o),
      .expiry_status_flag_o(expiry_status_flag_o), .sleep_entered_flag_o(sleep_entered_flag_o),
      .pin_change_wake_flag_o(pin_change_wake_flag_o), .file_addr_o(file_addr_o),
      .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .pc_load_o(pc_load_o),
      .pc_value_o(pc_value_o), .stack_pop_o(stack_pop_o),
      .watchdog_clear_o(watchdog_clear_o),
      .watchdog_prescaler_clear_o(watchdog_prescaler_clear_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Generous ceiling; the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] status_exp(input logic slp);
      return {16'h0, acc_m, 1'b0, slp, pin_change_wake_flag_i, ex_m, sl_m, z_m, dc_m, c_m};
   endfunction

   // Master holds everything until pready is sampled high; timeout cuts a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      // Look just after each edge, so the edge that follows sees pready high
      @(posedge clk_i);
      #1;
      while (pready !== 1'b1) begin
         @(posedge clk_i);
         #1;
      end
      rd = prdata;
      er = pslverr;
      @(posedge clk_i);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Model update first, then one instruction, then all results one cycle on
   task automatic run(input logic [11:0] ins, input logic [7:0] fv);
      logic [7:0] res;
      logic [PC_W-1:0] st;
      logic rot, sub, ret, slp, wr;
      st = PC_W'($urandom);
      rot = (ins & OP_FILE_OP_MASK) == OP_ROTATE;
      sub = (ins & OP_FILE_OP_MASK) == OP_SUBTRACT;
      ret = (ins & OP_RETURN_MASK) == OP_RETURN_LIT;
      slp = ins == OP_SLEEP;
      wr = (rot | sub) & ins[DEST_BIT];
      res = ret ? ins[7:0] : rot ? {c_m, fv[7:1]} : fv - acc_m;
      if (rot) c_m = fv[0];
      if (sub) begin
         c_m = fv >= acc_m;
         dc_m = fv[3:0] >= acc_m[3:0];
         z_m = res == 8'h00;
      end
      if (slp) begin
         ex_m = 1'b1;
         sl_m = 1'b0;
      end
      if ((rot | sub | ret) & !wr) acc_m = res;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= ins;
      file_rdata_i <= fv;
      stack_top_i <= st;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1 chk({acc_o, carry_o, dc_o, zero_o}, 32'({acc_m, c_m, dc_m, z_m}));
      chk({file_we_o, pc_load_o, stack_pop_o, busy_o}, 32'({wr, ret, ret, ret}));
      if (wr) chk({file_addr_o, file_wdata_o}, 32'({ins[4:0], res}));
      if (ret) chk(32'(pc_value_o), 32'(st));
      chk({watchdog_clear_o, watchdog_prescaler_clear_o, sleeping_o}, 32'({3{slp}}));
      chk({expiry_status_flag_o, sleep_entered_flag_o}, 32'({ex_m, sl_m}));
   endtask

   initial begin
      reset_i = 1'b1;
      {instr_valid_i, wake_i, psel, penable, pwrite} = 5'h00;
      {instr_i, paddr, pwdata, file_rdata_i, stack_top_i} = '0;
      void'($urandom(32'hd242));
      pin_change_wake_flag_i = 1'($urandom);
      {acc_m, c_m, dc_m, z_m, ex_m, sl_m} = {ACC_RESET, 3'b000, EXPIRY_RESET, SLEPT_RESET};
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      #1 chk({acc_o, expiry_status_flag_o, sleep_entered_flag_o}, 32'({acc_m, ex_m, sl_m}));
      // Worked examples: 3-2, 2-2, 1-2 into the file, then rotate of 0xe6
      run(OP_RETURN_LIT | 12'h002, 8'h00);
      run(OP_SUBTRACT | 12'h025, 8'h03);
      run(OP_SUBTRACT | 12'h025, 8'h02);
      run(OP_SUBTRACT | 12'h025, 8'h01);
      run(OP_ROTATE | 12'h005, 8'he6);
      // Opcode outside the subset must leave everything alone
      run(12'h0c5, 8'h3c);
      repeat (80) begin
         k = 12'($urandom_range(255, 0));
         case ($urandom_range(3, 0))
            0: run(OP_RETURN_LIT | k, 8'($urandom));
            1: run(OP_ROTATE | (k & 12'h03f), 8'($urandom));
            default: run(OP_SUBTRACT | (k & 12'h03f), 8'($urandom));
         endcase
      end
      // Subtract offered in the refetch cycle must be dropped
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= OP_RETURN_LIT | 12'h05a;
      @(posedge clk_i);
      instr_i <= OP_SUBTRACT | 12'h001;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1 chk({acc_o, busy_o, pc_load_o, file_we_o}, 32'({8'h5a, 3'b000}));
      acc_m = 8'h5a;
      // Sleep, refuse an instruction, read status, wake by wake_i
      run(OP_SLEEP, 8'h00);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1 chk({acc_o, file_we_o, watchdog_clear_o, sleeping_o}, 32'({acc_m, 3'b001}));
      chk(32'(pin_change_wake_flag_o), 32'(pin_change_wake_flag_i));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, status_exp(1'b1));
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk(32'(sleeping_o), 32'h0);
      // Status is read-only, unmapped place refused, control write wakes
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
      chk(32'(er), 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      run(OP_SLEEP, 8'h00);
      apb(1'b1, ADDR_CONTROL, 32'h1);
      repeat (2) @(posedge clk_i);
      #1 chk({er, sleeping_o}, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, status_exp(1'b0));
      tally_and_finish;
   end
endmodule
